// ---- include/rx_seq_pkg.sv ----
package rx_seq_pkg;

  // ==========================================================================
  // register map (byte offsets on the plain register port)
  localparam logic [7:0] ADDR_DATA_PORT    = 8'h00;  // buffer_data_port
  localparam logic [7:0] ADDR_MODE         = 8'h01;  // operating mode and header style
  localparam logic [7:0] ADDR_ACCESS_PTR   = 8'h02;  // buffer_access_pointer_reg
  localparam logic [7:0] ADDR_TX_BASE      = 8'h03;  // transmit_base_address
  localparam logic [7:0] ADDR_RX_BASE      = 8'h04;  // receive_base_address
  localparam logic [7:0] ADDR_LAST_START   = 8'h05;  // last_packet_start, read only
  localparam logic [7:0] ADDR_WRITE_POS    = 8'h06;  // receive_write_position, read only
  localparam logic [7:0] ADDR_BYTE_COUNT   = 8'h07;  // received_byte_count, read only
  localparam logic [7:0] ADDR_FLAGS        = 8'h08;  // interrupt_flag_set, write one to clear
  localparam logic [7:0] ADDR_MASK         = 8'h09;  // interrupt_mask_set
  localparam logic [7:0] ADDR_WINDOW_LOW   = 8'h0A;  // symbol_window_length, bits 7:0
  localparam logic [7:0] ADDR_WINDOW_HIGH  = 8'h0B;  // symbol_window_length, bits 9:8
  localparam logic [7:0] ADDR_PREAMBLE_HI  = 8'h0C;  // preamble_length_high
  localparam logic [7:0] ADDR_PREAMBLE_LO  = 8'h0D;  // preamble_length_low
  localparam logic [7:0] ADDR_PAYLOAD_LEN  = 8'h0E;  // payload_byte_count

  // ==========================================================================
  // operating mode codes and fields of the mode register
  localparam logic [1:0] MODE_SLEEP        = 2'h0;
  localparam logic [1:0] MODE_STANDBY      = 2'h1;
  localparam logic [1:0] MODE_SINGLE       = 2'h2;  // single_receive_mode
  localparam logic [1:0] MODE_CONT         = 2'h3;  // continuous_receive_mode
  localparam int         MODE_EXPLICIT_BIT = 2;

  // ==========================================================================
  // interrupt flag positions
  localparam int FLAG_HEADER  = 0;  // header_accepted_flag
  localparam int FLAG_CRC     = 1;  // payload_check_failed_flag
  localparam int FLAG_DONE    = 2;  // packet_received_flag
  localparam int FLAG_TIMEOUT = 3;  // receive_window_expired_flag
  localparam int FLAG_W       = 4;

  // ==========================================================================
  // widths and reset values
  localparam int          BUF_ADDR_W       = 8;
  localparam int          BUF_DEPTH        = 256;
  localparam int          WINDOW_W         = 10;
  localparam logic [9:0]  RST_WINDOW       = 10'h064;
  localparam logic [15:0] RST_PREAMBLE_LEN = 16'h0008;
  localparam logic [7:0]  RST_RX_BASE      = 8'h00;
  localparam logic [7:0]  RST_TX_BASE      = 8'h80;
  localparam logic [7:0]  RST_PAYLOAD_LEN  = 8'h01;
  localparam logic [3:0]  RST_MASK         = 4'h0;

  // ==========================================================================
  // receive sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEARCH,
    ST_PREAMBLE,
    ST_HEADER,
    ST_PAYLOAD
  } rx_state_type;

endpackage : rx_seq_pkg

// ---- hdl/symbol_timer.sv ----
`timescale 1ns/10ps

// counts down the receive window in symbol periods
module symbol_timer
  import rx_seq_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                ce,
  input  wire logic                start,
  input  wire logic                cancel,
  input  wire logic [WINDOW_W-1:0] load,
  input  wire logic                symbol_tick,
  output logic                     expired
);

  typedef struct packed {
    logic [WINDOW_W-1:0] count;
    logic                running;
    logic                expired;
  } timer_type;

  timer_type timer_reg;
  timer_type timer_next;

  // ==========================================================================
  // next state: a zero load expires on the first symbol, host keeps it in range
  always_comb begin
    timer_next         = timer_reg;
    timer_next.expired = 1'b0;
    if (cancel) begin
      timer_next.running = 1'b0;
    end else if (start) begin
      timer_next.count   = load;
      timer_next.running = 1'b1;
    end else if (timer_reg.running && symbol_tick) begin
      if (timer_reg.count <= 10'h001) begin
        timer_next.running = 1'b0;
        timer_next.expired = 1'b1;
      end else begin
        timer_next.count = timer_reg.count - 10'h001;
      end
    end
  end

  // ==========================================================================
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_reg <= '0;
    end else if (ce) begin
      timer_reg <= timer_next;
    end
  end

  assign expired = timer_reg.expired;

endmodule : symbol_timer

// ---- hdl/packet_buffer.sv ----
`timescale 1ns/10ps

// shared packet data buffer: modem write port plus host access port
module packet_buffer
  import rx_seq_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  ce,
  input  wire logic                  rx_we,
  input  wire logic [BUF_ADDR_W-1:0] rx_addr,
  input  wire logic [7:0]            rx_data,
  input  wire logic                  host_we,
  input  wire logic [BUF_ADDR_W-1:0] host_addr,
  input  wire logic [7:0]            host_wdata,
  output logic      [7:0]            host_rdata
);

  logic [7:0] mem [0:BUF_DEPTH-1];

  // ==========================================================================
  // modem wins a same-cycle clash; host should not fill during reception
  always_ff @(posedge mclk) begin
    if (ce) begin
      if (rx_we) begin
        mem[rx_addr] <= rx_data;
      end else if (host_we) begin
        mem[host_addr] <= host_wdata;
      end
    end
  end

  // unregistered read, the caller registers it onto the bus
  assign host_rdata = mem[host_addr];

endmodule : packet_buffer

// ---- hdl/rx_sequencer.sv ----
`timescale 1ns/10ps

// Behaviour
// - single: no preamble at window end, timeout, standby
// - payload end raises done, crc fail flag
// - bytes stored even on crc failure
// - single: done flag returns to standby
// - single: synth and front end off after packet
// - preamble, then gain fixed, then header flag if explicit
// - continuous: search, track, receive, search again
// - overlong preamble dropped silently, search restarts
// - continuous: never timeout, never self standby
// - continuous: contiguous bytes, write position kept
// - start and byte count only for latest packet; flags accumulate
// - single: no timeout mid packet; loss aborts
// - continuous: done per packet, stays receiving
// - write position is last address plus one
// - byte count of current packet payload
// - window timer starts at single mode entry
// - flags sticky until written with one
// - mask bit one disables; reset unmasked
module rx_sequencer
  import rx_seq_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        ce,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rdata,
  // demodulator events, same clock domain
  input  wire logic        symbol_tick,
  input  wire logic        preamble_detected,
  input  wire logic        preamble_locked,
  input  wire logic        header_valid,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  input  wire logic        payload_end,
  input  wire logic        payload_crc_ok,
  input  wire logic        track_lost,
  // radio control and status
  output logic [1:0]       mode_state,
  output logic             synth_enable,
  output logic             frontend_enable,
  output logic             gain_frozen,
  output logic [FLAG_W-1:0] flag_lines
);

  typedef struct packed {
    rx_state_type        state;
    logic [1:0]          mode;
    logic                explicit_hdr;
    logic [7:0]          access_ptr;
    logic [7:0]          tx_base;
    logic [7:0]          rx_base;
    logic [7:0]          last_start;
    logic [7:0]          write_pos;
    logic [7:0]          byte_count;
    logic [FLAG_W-1:0]   flags;
    logic [FLAG_W-1:0]   mask;
    logic [WINDOW_W-1:0] window_len;
    logic [15:0]         preamble_len;
    logic [15:0]         preamble_cnt;
    logic [7:0]          payload_len;
    logic                window_over;
    logic                timer_start;
    logic [7:0]          rdata;
    logic [FLAG_W-1:0]   flag_lines;
    logic                synth_en;
    logic                frontend_en;
    logic                gain_frozen;
  } seq_type;

  seq_type seq_reg;
  seq_type seq_next;

  logic              rst_meta;
  logic              rst_sync;
  logic              timer_expired;
  logic [7:0]        buf_rdata;
  logic              host_buf_we;
  logic              rx_buf_we;
  logic              mode_wr;
  logic              preamble_overrun;
  logic [FLAG_W-1:0] flag_set;
  logic [FLAG_W-1:0] flag_clr;

  // ==========================================================================
  // reset release: asserts at once, leaves only after two clean edges
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ==========================================================================
  // window timer and packet buffer
  symbol_timer u_timer (
    .mclk        (mclk),
    .rst_n       (rst_sync),
    .ce          (ce),
    .start       (seq_reg.timer_start),
    .cancel      (seq_reg.mode != MODE_SINGLE),
    .load        (seq_reg.window_len),
    .symbol_tick (symbol_tick),
    .expired     (timer_expired)
  );

  packet_buffer u_buffer (
    .mclk       (mclk),
    .ce         (ce),
    .rx_we      (rx_buf_we),
    .rx_addr    (seq_reg.write_pos),
    .rx_data    (byte_data),
    .host_we    (host_buf_we),
    .host_addr  (seq_reg.access_ptr),
    .host_wdata (wdata),
    .host_rdata (buf_rdata)
  );

  // ==========================================================================
  // strobes and events shared by the sequencer and the checks below
  assign mode_wr          = wr_en && (addr == ADDR_MODE);
  assign host_buf_we      = wr_en && (addr == ADDR_DATA_PORT);
  // bytes land whatever the crc later says
  assign rx_buf_we        = ce && (seq_reg.state == ST_PAYLOAD) && byte_valid;
  assign flag_clr         = (wr_en && (addr == ADDR_FLAGS)) ? wdata[FLAG_W-1:0] : '0;
  assign preamble_overrun = (seq_reg.state == ST_PREAMBLE) && !track_lost && !preamble_locked
                            && symbol_tick && (seq_reg.preamble_cnt >= seq_reg.preamble_len);

  // ==========================================================================
  // next state: sequencer first, then host accesses, host mode write wins
  always_comb begin
    seq_next             = seq_reg;
    seq_next.timer_start = 1'b0;
    flag_set             = '0;
    if (seq_reg.mode == MODE_SINGLE && timer_expired) begin
      seq_next.window_over = 1'b1;
    end
    // receive sequencer
    unique case (seq_reg.state)
      ST_IDLE: begin
      end
      ST_SEARCH: begin
        if (seq_reg.mode == MODE_SINGLE && (seq_reg.window_over || timer_expired)) begin
          flag_set[FLAG_TIMEOUT] = 1'b1;
          seq_next.mode          = MODE_STANDBY;
          seq_next.state         = ST_IDLE;
          seq_next.synth_en      = 1'b0;
          seq_next.frontend_en   = 1'b0;
        end else if (preamble_detected) begin
          seq_next.state        = ST_PREAMBLE;
          seq_next.preamble_cnt = '0;
        end
      end
      ST_PREAMBLE: begin
        if (track_lost) begin
          seq_next.state = ST_SEARCH;
        end else if (preamble_locked) begin
          seq_next.gain_frozen = 1'b1;
          if (seq_reg.explicit_hdr) begin
            seq_next.state = ST_HEADER;
          end else begin
            seq_next.state      = ST_PAYLOAD;
            seq_next.last_start = seq_reg.write_pos;
            seq_next.byte_count = '0;
          end
        end else if (preamble_overrun) begin
          seq_next.state = ST_SEARCH;
        end else if (symbol_tick) begin
          seq_next.preamble_cnt = seq_reg.preamble_cnt + 16'h0001;
        end
      end
      ST_HEADER, ST_PAYLOAD: begin
        if (seq_reg.state == ST_HEADER && header_valid && !track_lost) begin
          flag_set[FLAG_HEADER] = 1'b1;
          seq_next.state        = ST_PAYLOAD;
          seq_next.last_start   = seq_reg.write_pos;
          seq_next.byte_count   = '0;
        end
        if (rx_buf_we) begin
          seq_next.write_pos  = seq_reg.write_pos + 8'h01;
          seq_next.byte_count = seq_reg.byte_count + 8'h01;
        end
        if (track_lost) begin
          seq_next.gain_frozen = 1'b0;
          if (seq_reg.mode == MODE_SINGLE) begin
            flag_set[FLAG_TIMEOUT] = 1'b1;
            seq_next.mode          = MODE_STANDBY;
            seq_next.state         = ST_IDLE;
            seq_next.synth_en      = 1'b0;
            seq_next.frontend_en   = 1'b0;
          end else begin
            seq_next.state = ST_SEARCH;
          end
        end else if (seq_reg.state == ST_PAYLOAD && payload_end) begin
          // flags add to those of earlier packets until the host clears them
          flag_set[FLAG_DONE]  = 1'b1;
          flag_set[FLAG_CRC]   = !payload_crc_ok;
          seq_next.gain_frozen = 1'b0;
          if (seq_reg.mode == MODE_SINGLE) begin
            seq_next.mode        = MODE_STANDBY;
            seq_next.state       = ST_IDLE;
            seq_next.synth_en    = 1'b0;
            seq_next.frontend_en = 1'b0;
          end else begin
            seq_next.state = ST_SEARCH;
          end
        end
      end
    endcase
    // sticky flags: a set in the clearing cycle survives
    seq_next.flags      = (seq_reg.flags & ~flag_clr) | flag_set;
    seq_next.flag_lines = seq_reg.flags & ~seq_reg.mask;
    // host writes
    if (wr_en) begin
      unique case (addr)
        ADDR_DATA_PORT:   seq_next.access_ptr = seq_reg.access_ptr + 8'h01;
        ADDR_ACCESS_PTR:  seq_next.access_ptr = wdata;
        ADDR_TX_BASE:     seq_next.tx_base = wdata;
        ADDR_RX_BASE:     seq_next.rx_base = wdata;
        ADDR_MASK:        seq_next.mask = wdata[FLAG_W-1:0];
        ADDR_WINDOW_LOW:  seq_next.window_len[7:0] = wdata;
        ADDR_WINDOW_HIGH: seq_next.window_len[WINDOW_W-1:8] = wdata[WINDOW_W-9:0];
        ADDR_PREAMBLE_HI: seq_next.preamble_len[15:8] = wdata;
        ADDR_PREAMBLE_LO: seq_next.preamble_len[7:0] = wdata;
        ADDR_PAYLOAD_LEN: seq_next.payload_len = wdata;
        ADDR_MODE: begin
          seq_next.mode         = wdata[1:0];
          seq_next.explicit_hdr = wdata[MODE_EXPLICIT_BIT];
          seq_next.gain_frozen  = 1'b0;
          if (wdata[1:0] == MODE_SINGLE || wdata[1:0] == MODE_CONT) begin
            seq_next.state       = ST_SEARCH;
            seq_next.synth_en    = 1'b1;
            seq_next.frontend_en = 1'b1;
            seq_next.window_over = 1'b0;
            seq_next.timer_start = (wdata[1:0] == MODE_SINGLE);
            // reentering the same receive mode keeps the write position
            if (wdata[1:0] != seq_reg.mode) begin
              seq_next.write_pos = seq_reg.rx_base;
            end
          end else begin
            seq_next.state       = ST_IDLE;
            seq_next.synth_en    = 1'b0;
            seq_next.frontend_en = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // host reads, answered in the next cycle only
    seq_next.rdata = '0;
    if (rd_en) begin
      unique case (addr)
        ADDR_DATA_PORT: begin
          seq_next.rdata      = buf_rdata;
          seq_next.access_ptr = seq_reg.access_ptr + 8'h01;
        end
        ADDR_MODE:        seq_next.rdata = {5'h00, seq_reg.explicit_hdr, seq_reg.mode};
        ADDR_ACCESS_PTR:  seq_next.rdata = seq_reg.access_ptr;
        ADDR_TX_BASE:     seq_next.rdata = seq_reg.tx_base;
        ADDR_RX_BASE:     seq_next.rdata = seq_reg.rx_base;
        ADDR_LAST_START:  seq_next.rdata = seq_reg.last_start;
        ADDR_WRITE_POS:   seq_next.rdata = seq_reg.write_pos;
        ADDR_BYTE_COUNT:  seq_next.rdata = seq_reg.byte_count;
        ADDR_FLAGS:       seq_next.rdata = {4'h0, seq_reg.flags};
        ADDR_MASK:        seq_next.rdata = {4'h0, seq_reg.mask};
        ADDR_WINDOW_LOW:  seq_next.rdata = seq_reg.window_len[7:0];
        ADDR_WINDOW_HIGH: seq_next.rdata = {6'h00, seq_reg.window_len[WINDOW_W-1:8]};
        ADDR_PREAMBLE_HI: seq_next.rdata = seq_reg.preamble_len[15:8];
        ADDR_PREAMBLE_LO: seq_next.rdata = seq_reg.preamble_len[7:0];
        ADDR_PAYLOAD_LEN: seq_next.rdata = seq_reg.payload_len;
        default:          seq_next.rdata = '0;
      endcase
    end
  end

  // ==========================================================================
  // state register, frozen while ce is low
  always_ff @(posedge mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      seq_reg              <= '0;
      seq_reg.state        <= ST_IDLE;
      seq_reg.mode         <= MODE_STANDBY;
      seq_reg.tx_base      <= RST_TX_BASE;
      seq_reg.rx_base      <= RST_RX_BASE;
      seq_reg.mask         <= RST_MASK;
      seq_reg.window_len   <= RST_WINDOW;
      seq_reg.preamble_len <= RST_PREAMBLE_LEN;
      seq_reg.payload_len  <= RST_PAYLOAD_LEN;
    end else if (ce) begin
      seq_reg <= seq_next;
    end
  end

  assign rdata           = seq_reg.rdata;
  assign mode_state      = seq_reg.mode;
  assign synth_enable    = seq_reg.synth_en;
  assign frontend_enable = seq_reg.frontend_en;
  assign gain_frozen     = seq_reg.gain_frozen;
  assign flag_lines      = seq_reg.flag_lines;

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync);

  a_window_timeout: assert property (ce && !mode_wr && seq_reg.state == ST_SEARCH
      && seq_reg.mode == MODE_SINGLE && timer_expired
      |=> seq_reg.flags[FLAG_TIMEOUT] && seq_reg.mode == MODE_STANDBY && !seq_reg.synth_en)
    else $error("window expiry did not flag timeout and stand by");

  a_done_crc_flags: assert property (ce && !mode_wr && !track_lost
      && seq_reg.state == ST_PAYLOAD && payload_end
      |=> seq_reg.flags[FLAG_DONE] && (seq_reg.flags[FLAG_CRC] || $past(payload_crc_ok)))
    else $error("payload end flags wrong");

  a_single_standby: assert property (ce && !mode_wr && !track_lost
      && seq_reg.state == ST_PAYLOAD && payload_end && seq_reg.mode == MODE_SINGLE
      |=> seq_reg.mode == MODE_STANDBY && seq_reg.state == ST_IDLE)
    else $error("single receive did not return to standby");

  a_power_down: assert property (seq_reg.state == ST_IDLE
      |-> !seq_reg.synth_en && !seq_reg.frontend_en)
    else $error("radio powered while sequencer idle");

  a_preamble_drop: assert property (ce && !wr_en && preamble_overrun
      |=> seq_reg.state == ST_SEARCH && seq_reg.flags == $past(seq_reg.flags))
    else $error("overlong preamble not dropped silently");

  a_cont_no_timeout: assert property (ce && !mode_wr && seq_reg.mode == MODE_CONT
      |=> !$rose(seq_reg.flags[FLAG_TIMEOUT]) && seq_reg.mode == MODE_CONT)
    else $error("continuous mode timed out or left on its own");

  a_cont_next_packet: assert property (ce && !mode_wr && !track_lost
      && seq_reg.state == ST_PAYLOAD && payload_end && seq_reg.mode == MODE_CONT
      |=> seq_reg.state == ST_SEARCH && seq_reg.flags[FLAG_DONE])
    else $error("continuous mode did not rearm after packet");

  a_lost_abort: assert property (ce && !mode_wr && track_lost && seq_reg.mode == MODE_SINGLE
      && (seq_reg.state == ST_HEADER || seq_reg.state == ST_PAYLOAD)
      |=> seq_reg.flags[FLAG_TIMEOUT] && seq_reg.mode == MODE_STANDBY)
    else $error("lost packet not aborted");

  a_write_advance: assert property (rx_buf_we && !mode_wr
      |=> seq_reg.write_pos == $past(seq_reg.write_pos) + 8'h01
       && seq_reg.byte_count == $past(seq_reg.byte_count) + 8'h01)
    else $error("write position or byte count did not advance");

  a_pointer_advance: assert property (ce && (rd_en || wr_en) && addr == ADDR_DATA_PORT
      |=> seq_reg.access_ptr == $past(seq_reg.access_ptr) + 8'h01)
    else $error("access pointer did not advance");

  a_flag_sticky: assert property (ce && seq_reg.flags[FLAG_DONE]
      && !(wr_en && addr == ADDR_FLAGS && wdata[FLAG_DONE])
      |=> seq_reg.flags[FLAG_DONE])
    else $error("done flag dropped without a clear");

  a_mask_gate: assert property (ce ##1 ce
      |-> seq_reg.flag_lines == ($past(seq_reg.flags) & ~$past(seq_reg.mask)))
    else $error("flag lines disagree with flags and mask");

endmodule : rx_sequencer

// ---- testbench/host_model.sv ----
`timescale 1ns/10ps

// ====
// register host: every change lands just after a rising edge
module host_model
  import rx_seq_pkg::*;
(
  input  wire logic       mclk,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr_en,
  output logic            rd_en,
  input  wire logic [7:0] rdata
);
  initial {addr, wdata, wr_en, rd_en} = 18'h00000;
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // rearm: pointer back to receive base before the mode
  task automatic arm(input logic [7:0] m);
    wr(ADDR_ACCESS_PTR, RST_RX_BASE);
    wr(ADDR_MODE, m);
  endtask : arm
endmodule : host_model

// ---- testbench/tb_rx_sequencer.sv ----
`timescale 1ns/10ps

module tb_rx_sequencer import rx_seq_pkg::*;;
  logic       mclk = 1'b0;
  logic       arst_n = 1'b0;
  logic [7:0] addr, wdata, rdata, bd, v;
  logic       wr_en, rd_en, crc_ok, synth_enable, frontend_enable, gain_frozen;
  logic [6:0] ev;
  logic [1:0] mode_state;
  logic [3:0] flag_lines;
  int         err_count, n_compared;
  // ====
  // 50 ns clock; only ce is tied, so the whole sequencer is reachable
  always #25 mclk = ~mclk;
  host_model h (.mclk, .addr, .wdata, .wr_en, .rd_en, .rdata);
  rx_sequencer uut (.mclk, .arst_n, .ce(1'b1), .addr, .wdata, .wr_en, .rd_en, .rdata,
    .symbol_tick(ev[0]), .preamble_detected(ev[1]), .preamble_locked(ev[2]),
    .header_valid(ev[3]), .byte_valid(ev[4]), .byte_data(bd), .payload_end(ev[5]),
    .payload_crc_ok(crc_ok), .track_lost(ev[6]), .mode_state, .synth_enable,
    .frontend_enable, .gain_frozen, .flag_lines);
  // one-cycle demodulator event, bit i of ev
  task automatic pulse(input int i);
    @(posedge mclk);
    ev <= 7'h01 << i;
    @(posedge mclk);
    ev <= 7'h00;
  endtask : pulse
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string n);
    h.rd(a, v);
    chk(n, e, v);
  endtask : rchk
  // window of 4 symbols, the shortest legal one
  task automatic t_timeout;
    h.wr(ADDR_WINDOW_LOW, 8'h04);
    h.wr(ADDR_WINDOW_HIGH, 8'h00);
    h.arm({6'h00, MODE_SINGLE});
    repeat (2) @(posedge mclk);
    repeat (3) pulse(0);
    #1 chk("mode", {6'h00, MODE_SINGLE}, {6'h00, mode_state});
    pulse(0);
    // expiry lands in the timer first, the sequencer answers one edge later
    @(posedge mclk);
    #1 chk("mode", {6'h00, MODE_STANDBY}, {6'h00, mode_state});
    rchk(ADDR_FLAGS, 8'h08, "flags");
    chk("lines", 8'h08, {4'h0, flag_lines});
    h.wr(ADDR_FLAGS, 8'h0F);
    rchk(ADDR_FLAGS, 8'h00, "flags");
    $display("test timeout done");
  endtask : t_timeout
  // explicit header, bad payload check: bytes must still land
  task automatic t_single;
    h.arm(8'h06);
    repeat (2) @(posedge mclk);
    pulse(1);
    pulse(2);
    pulse(3);
    #1 chk("rx", 8'h07, {5'h00, gain_frozen, synth_enable, frontend_enable});
    for (int k = 0; k < 3; k++) begin
      bd <= 8'hA1 + 8'(k);
      pulse(4);
    end
    crc_ok <= 1'b0;
    pulse(5);
    #1 chk("mode", {6'h00, MODE_STANDBY}, {6'h00, mode_state});
    chk("power", 8'h00, {6'h00, synth_enable, frontend_enable});
    rchk(ADDR_FLAGS, 8'h07, "flags");
    rchk(ADDR_WRITE_POS, 8'h03, "wpos");
    rchk(ADDR_BYTE_COUNT, 8'h03, "count");
    h.rd(ADDR_LAST_START, v);
    h.wr(ADDR_ACCESS_PTR, v);
    for (int k = 0; k < 3; k++) rchk(ADDR_DATA_PORT, 8'hA1 + 8'(k), "data");
    h.wr(ADDR_FLAGS, 8'h0F);
    // transmit fill from the transmit base, read back through the same port
    rchk(ADDR_TX_BASE, RST_TX_BASE, "txbase");
    h.wr(ADDR_PAYLOAD_LEN, 8'h02);
    h.wr(ADDR_ACCESS_PTR, RST_TX_BASE);
    for (int k = 0; k < 2; k++) h.wr(ADDR_DATA_PORT, 8'h3C + 8'(k));
    h.wr(ADDR_ACCESS_PTR, RST_TX_BASE);
    for (int k = 0; k < 2; k++) rchk(ADDR_DATA_PORT, 8'h3C + 8'(k), "tx");
    $display("test single done");
  endtask : t_single
  // window runs out mid packet, then track loss aborts; sleep before rearm
  task automatic t_lost;
    h.arm({6'h00, MODE_SINGLE});
    pulse(1);
    pulse(2);
    repeat (5) pulse(0);
    #1 chk("mode", {6'h00, MODE_SINGLE}, {6'h00, mode_state});
    rchk(ADDR_FLAGS, 8'h00, "flags");
    pulse(6);
    #1 chk("mode", {6'h00, MODE_STANDBY}, {6'h00, mode_state});
    rchk(ADDR_FLAGS, 8'h08, "flags");
    h.wr(ADDR_MODE, {6'h00, MODE_SLEEP});
    #1 chk("mode", {6'h00, MODE_SLEEP}, {6'h00, mode_state});
    h.wr(ADDR_FLAGS, 8'h0F);
    $display("test lost done");
  endtask : t_lost
  // overlong preamble first, then two packets back to back
  task automatic t_cont;
    h.arm({6'h00, MODE_CONT});
    crc_ok <= 1'b1;
    pulse(1);
    repeat (9) pulse(0);
    pulse(2);
    #1 chk("gain", 8'h00, {7'h00, gain_frozen});
    for (int p = 0; p < 2; p++) begin
      pulse(1);
      pulse(2);
      bd <= 8'h50 + 8'(p);
      pulse(4);
      pulse(5);
    end
    repeat (6) pulse(0);
    #1 chk("mode", {6'h00, MODE_CONT}, {6'h00, mode_state});
    rchk(ADDR_FLAGS, 8'h04, "flags");
    rchk(ADDR_WRITE_POS, 8'h02, "wpos");
    h.wr(ADDR_ACCESS_PTR, 8'h00);
    for (int k = 0; k < 2; k++) rchk(ADDR_DATA_PORT, 8'h50 + 8'(k), "data");
    $display("test continuous done");
  endtask : t_cont
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  // tests need well under 1000 cycles; a hang stops here
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    print_verdict();
  end
  initial begin
    {ev, bd, crc_ok} = 16'h0001;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_timeout();
    t_single();
    t_lost();
    t_cont();
    print_verdict();
  end
endmodule : tb_rx_sequencer
